// >>> shared/drc_pkg.sv
package drc_pkg;
  localparam int COUNT_W = 16;
  localparam int NUM_CNT = 2;
  localparam logic [COUNT_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int CNT_RATE_HZ = 10000000;
  localparam int TICK_DIV = SYS_CLK_HZ / CNT_RATE_HZ;
  localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
endpackage

// >>> verification/drc_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
module drc_proc_model
  import drc_pkg::*;
(
  input wire logic clk_i,                    // system clock
  input wire logic [NUM_CNT-1:0] timer_tc_i, // internal timer inputs
  input wire logic [NUM_CNT-1:0] pin_tc_i,   // external pins
  output logic [COUNT_W-1:0] tn_o,           // pulses on internal input 0
  output logic [COUNT_W-1:0] pn_o,           // pulses on pin 0
  output logic [COUNT_W-1:0] gap_o,          // clocks between last two pulses on input 0 or pin 0
  output logic wide_o                        // a pulse lasted over one cycle
);
  logic [COUNT_W-1:0] run = 16'h0000;
  logic [NUM_CNT-1:0] last_t = 2'h0, last_p = 2'h0;
  initial {tn_o, pn_o, gap_o, wide_o} = 49'h0;
  always @(posedge clk_i) begin
    tn_o <= tn_o + {15'h0, timer_tc_i[0]};
    pn_o <= pn_o + {15'h0, pin_tc_i[0]};
    run <= (timer_tc_i[0] | pin_tc_i[0]) ? 16'h0001 : run + 16'h0001;
    if (timer_tc_i[0] | pin_tc_i[0]) gap_o <= run;
    wide_o <= wide_o | (|(timer_tc_i & last_t)) | (|(pin_tc_i & last_p));
    last_t <= timer_tc_i;
    last_p <= pin_tc_i;
  end
endmodule
`default_nettype wire

// >>> verification/tb_dual_reload_down_counters.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_reload_down_counters;
  import drc_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, power_down_i = 1'h0, ext_proc_i = 1'h0, wide;
  logic [NUM_CNT-1:0] enable_i = 2'h0, reload_we_i = 2'h0, timer_tc_o, pin_tc_o;
  logic [COUNT_W-1:0] reload_data_i = 16'h0000, count0_o, count1_o, tn, pn, gap, hold;
  int mismatches = 0, num_checks = 0, cycles = 0;
  drc_dual_counters dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .power_down_i(power_down_i),
    .ext_proc_i(ext_proc_i), .enable_i(enable_i), .reload_we_i(reload_we_i),
    .reload_data_i(reload_data_i), .timer_tc_o(timer_tc_o), .pin_tc_o(pin_tc_o),
    .count0_o(count0_o), .count1_o(count1_o));
  drc_proc_model proc (.clk_i(clk_i), .timer_tc_i(timer_tc_o), .pin_tc_i(pin_tc_o),
    .tn_o(tn), .pn_o(pn), .gap_o(gap), .wide_o(wide));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string what, input logic [COUNT_W-1:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input int g, input logic [COUNT_W-1:0] v);
    reload_data_i = v;
    reload_we_i[g] = 1'h1;
    step(1);
    reload_we_i = 2'h0;
  endtask
  // period of reload 3 is four ticks, eight clocks
  task automatic t_period();
    wr(0, 16'h0003);
    enable_i[0] = 1'h1;
    step(30);
    chk("tc gap", 16'h0008, gap);
    chk("tc wide", 16'h0000, {15'h0, wide});
    chk("timer tc int", 16'h0003, tn);
    chk("pin tc int", 16'h0000, pn);
    chk("count1 idle", 16'h0000, count1_o);
  endtask
  task automatic t_hold();
    wr(1, 16'h1234);
    step(3);
    chk("count1 load", 16'h1234, count1_o);
  endtask
  task automatic t_ext();
    logic [COUNT_W-1:0] t0, p0;
    ext_proc_i = 1'h1;
    step(2);
    t0 = tn;
    p0 = pn;
    step(40);
    chk("timer tc ext", t0, tn);
    chk("pin tc ext", p0 + 16'h0005, pn);
    ext_proc_i = 1'h0;
  endtask
  task automatic t_pd();
    power_down_i = 1'h1;
    step(2);
    hold = count0_o;
    wr(1, 16'h5555);
    step(10);
    chk("count0 pd", hold, count0_o);
    chk("count1 pd write", 16'h1234, count1_o);
    power_down_i = 1'h0;
  endtask
  task automatic t_dis();
    enable_i = 2'h0;
    step(3);
    hold = count0_o;
    step(10);
    chk("count0 disabled", hold, count0_o);
  endtask
  initial begin
    step(4);
    rst_n_i = 1'h1;
    step(1);
    t_period();
    t_hold();
    t_ext();
    t_pd();
    t_dis();
    conclude();
  end
endmodule
`default_nettype wire

// >>> verilog/drc_down_counter.sv
`timescale 1ns/1ps
`default_nettype none
module drc_down_counter
  import drc_pkg::*;
#(
  parameter int WIDTH = COUNT_W
) (
  input wire logic clk_i,               // system clock
  input wire logic rst_n_i,             // async reset, active low
  input wire logic tick_i,              // count-rate strobe
  input wire logic enable_i,            // counting allowed
  input wire logic [WIDTH-1:0] reload_i, // reload value
  input wire logic load_i,              // software reload strobe
  output logic [WIDTH-1:0] count_o,     // current count
  output logic tc_o                     // terminal count pulse
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_tc;
  wire at_zero = (count == WIDTH'(COUNT_ZERO));
  wire step = enable_i && tick_i;
  // zero reached: reload and pulse, else step down
  assign next_count = load_i ? reload_i :
                      !step ? count :
                      at_zero ? reload_i :
                      count - WIDTH'(COUNT_STEP);
  assign next_tc = step && at_zero && !load_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= WIDTH'(COUNT_RST);
      tc_o <= 1'h0;
    end else begin
      count <= next_count;
      tc_o <= next_tc;
    end
  end
  assign count_o = count;
  ////////////////////////////////////////////////////////////////////////
  chk_hold_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!step && !load_i) |=> $stable(count))
    else $error("count moved while idle");
  chk_decrement_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step && !at_zero && !load_i) |=> (count == $past(count) - WIDTH'(COUNT_STEP)))
    else $error("count did not decrement");
  chk_zero_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step && at_zero && !load_i) |=> (count == $past(reload_i)) && tc_o)
    else $error("no reload at zero");
  chk_tc_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tc_o |=> !tc_o || $past(step && at_zero && !load_i))
    else $error("terminal count too long");
  cov_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i) tc_o);
endmodule
`default_nettype wire

// >>> verilog/drc_dual_counters.sv
// Function
// - Two independent down counters, each 16 bits wide.
// - Each counter starts every countdown period from a software-written reload value.
// - While enabled a counter decrements by one per 10 MHz count tick with no software help.
// - On reaching zero a counter signals terminal count and reloads, then keeps counting.
// - Terminal counts go to the internal processor timer inputs or, in external mode, to pins.
// - While the block power-down bit is set the prescaler, counts and reload registers hold and no new terminal count is raised.
`timescale 1ns/1ps
`default_nettype none
module drc_dual_counters
  import drc_pkg::*;
#(
  parameter int WIDTH = COUNT_W,
  parameter int DIV = TICK_DIV
) (
  input wire logic clk_i,                    // 20 MHz system clock
  input wire logic rst_n_i,                  // async reset, active low
  input wire logic power_down_i,             // block power-down bit
  input wire logic ext_proc_i,               // external processor selected
  input wire logic [NUM_CNT-1:0] enable_i,   // per-counter enable
  input wire logic [NUM_CNT-1:0] reload_we_i, // reload write strobe
  input wire logic [WIDTH-1:0] reload_data_i, // reload write data
  output logic [NUM_CNT-1:0] timer_tc_o,     // to internal timer inputs
  output logic [NUM_CNT-1:0] pin_tc_o,       // to external pins
  output logic [WIDTH-1:0] count0_o,         // counter 0 value
  output logic [WIDTH-1:0] count1_o          // counter 1 value
);
  ////////////////////////////////////////////////////////////////////////
  // count-rate prescaler, frozen while powered down
  localparam int PRESC_W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [PRESC_W-1:0] presc;
  wire presc_last = (presc == PRESC_W'(DIV - 1));
  wire run = !power_down_i;
  wire tick = run && presc_last;
  wire [PRESC_W-1:0] next_presc = !run ? presc :
                                  presc_last ? '0 : presc + PRESC_W'(1);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0] reload [NUM_CNT];
  logic [WIDTH-1:0] count [NUM_CNT];
  logic [NUM_CNT-1:0] tc;
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    wire wr = reload_we_i[g] && run;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        reload[g] <= WIDTH'(RELOAD_RST);
      end else if (wr) begin
        reload[g] <= reload_data_i;
      end
    end
    drc_down_counter #(.WIDTH(WIDTH)) u_cnt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .enable_i(enable_i[g] && run),
      .reload_i(wr ? reload_data_i : reload[g]),
      .load_i(wr),
      .count_o(count[g]),
      .tc_o(tc[g])
    );
  end
  ////////////////////////////////////////////////////////////////////////
  // route terminal counts by processor mode
  function automatic logic [NUM_CNT-1:0] pass_tc(input logic pick,
                                                 input logic [NUM_CNT-1:0] pulses);
    return pick ? pulses : '0;
  endfunction
  wire [NUM_CNT-1:0] next_timer_tc = pass_tc(!ext_proc_i, tc);
  wire [NUM_CNT-1:0] next_pin_tc = pass_tc(ext_proc_i, tc);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_tc_o <= '0;
      pin_tc_o <= '0;
      count0_o <= '0;
      count1_o <= '0;
    end else begin
      timer_tc_o <= next_timer_tc;
      pin_tc_o <= next_pin_tc;
      count0_o <= count[0];
      count1_o <= count[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checker helper: ticks between counter 0 terminal counts, trusted only
  // after a full period with no reload write in between
  localparam int SPAN_W = WIDTH + 1;
  logic [SPAN_W-1:0] ticks0;
  logic clean0;
  wire step0 = tick && enable_i[0];
  wire wr0 = reload_we_i[0] && run;
  wire [SPAN_W-1:0] next_ticks0 = tc[0] ? SPAN_W'(step0) :
                                  step0 ? ticks0 + SPAN_W'(1) : ticks0;
  wire next_clean0 = !wr0 && (tc[0] || clean0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ticks0 <= '0;
      clean0 <= 1'h0;
    end else begin
      ticks0 <= next_ticks0;
      clean0 <= next_clean0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // routing and output registers
  chk_route_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_proc_i |=> (timer_tc_o == '0) && (pin_tc_o == $past(tc)))
    else $error("terminal count not on pins");
  chk_route_int: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ext_proc_i |=> (pin_tc_o == '0) && (timer_tc_o == $past(tc)))
    else $error("terminal count not on timer inputs");
  chk_route_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(|(timer_tc_o & pin_tc_o)))
    else $error("terminal count on both routes");
  chk_tc_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tc[0] |=> (timer_tc_o[0] || pin_tc_o[0]))
    else $error("terminal count lost");
  chk_tc_route1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tc[1] |=> (timer_tc_o[1] || pin_tc_o[1]))
    else $error("terminal count 1 lost");
  chk_out_idle0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tc[0] |=> (!timer_tc_o[0] && !pin_tc_o[0]))
    else $error("spurious terminal count 0");
  chk_out_idle1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tc[1] |=> (!timer_tc_o[1] && !pin_tc_o[1]))
    else $error("spurious terminal count 1");
  chk_count0_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'h1 |=> (count0_o == $past(count[0])))
    else $error("count0 output wrong");
  chk_count1_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'h1 |=> (count1_o == $past(count[1])))
    else $error("count1 output wrong");
  // power down
  chk_pd_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i |=> $stable(count[0]) && $stable(count[1]))
    else $error("count moved in power down");
  chk_pd_presc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i |=> $stable(presc))
    else $error("prescaler moved in power down");
  chk_pd_no_tc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i |=> (tc == '0))
    else $error("terminal count in power down");
  chk_pd_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i |=> $stable(reload[0]) && $stable(reload[1]))
    else $error("reload written in power down");
  // count rate
  chk_tick_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV > 1) && tick) |=> !tick)
    else $error("count ticks too close");
  chk_tick_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV == 2) && tick) ##1 run ##1 run |-> tick)
    else $error("count tick missing");
  // reload and period
  chk_reload_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[0] && run) |=> reload[0] == $past(reload_data_i))
    else $error("reload not stored");
  chk_reload_store1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[1] && run) |=> reload[1] == $past(reload_data_i))
    else $error("reload 1 not stored");
  chk_reload_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(reload_we_i[0] && run) |=> $stable(reload[0]))
    else $error("reload changed without write");
  chk_reload_hold1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(reload_we_i[1] && run) |=> $stable(reload[1]))
    else $error("reload 1 changed without write");
  chk_write_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[0] && run) |=> (count[0] == $past(reload_data_i)))
    else $error("write did not restart count");
  chk_write_restart1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[1] && run) |=> (count[1] == $past(reload_data_i)))
    else $error("write did not restart count 1");
  chk_load_no_tc0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[0] && run) |=> !tc[0])
    else $error("terminal count on reload write");
  chk_load_no_tc1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reload_we_i[1] && run) |=> !tc[1])
    else $error("terminal count 1 on reload write");
  chk_period_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tc[0] && clean0) |-> (ticks0 == SPAN_W'(reload[0]) + SPAN_W'(1)))
    else $error("countdown period wrong");
  chk_tc_at_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tc[0] |-> ($past(count[0]) == WIDTH'(COUNT_ZERO)))
    else $error("terminal count away from zero");
  chk_tc_at_zero1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tc[1] |-> ($past(count[1]) == WIDTH'(COUNT_ZERO)))
    else $error("terminal count 1 away from zero");
  // pulse width and holds
  chk_timer_pulse0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV > 1) && timer_tc_o[0]) |=> !timer_tc_o[0])
    else $error("timer pulse 0 too long");
  chk_timer_pulse1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV > 1) && timer_tc_o[1]) |=> !timer_tc_o[1])
    else $error("timer pulse 1 too long");
  chk_pin_pulse0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV > 1) && pin_tc_o[0]) |=> !pin_tc_o[0])
    else $error("pin pulse 0 too long");
  chk_pin_pulse1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((DIV > 1) && pin_tc_o[1]) |=> !pin_tc_o[1])
    else $error("pin pulse 1 too long");
  chk_hold_off0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enable_i[0] && !reload_we_i[0]) |=> $stable(count[0]))
    else $error("count0 moved while disabled");
  chk_hold_off1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enable_i[1] && !reload_we_i[1]) |=> $stable(count[1]))
    else $error("count1 moved while disabled");
  chk_no_tc_off0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enable_i[0] |=> !tc[0])
    else $error("terminal count 0 while disabled");
  chk_no_tc_off1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enable_i[1] |=> !tc[1])
    else $error("terminal count 1 while disabled");
  cov_tc_int: cover property (@(posedge clk_i) disable iff (!rst_n_i) timer_tc_o[0]);
  cov_tc_ext: cover property (@(posedge clk_i) disable iff (!rst_n_i) pin_tc_o[0]);
  cov_pd: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i ##1 !power_down_i);
  cov_pd_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    power_down_i && reload_we_i[1]);
endmodule
`default_nettype wire
